//--- i2c_slave_regs.svh
// Constants of the two-wire slave address, reset and identification front end
`ifndef I2C_SLAVE_REGS_SVH
`define I2C_SLAVE_REGS_SVH

`define GC_WRITE_BYTE   8'h00
`define GC_READ_BYTE    8'h01
`define SW_RESET_BYTE   8'h06
`define ID_ADDR         7'h7c
`define RW_READ         1'b1
`define RW_WRITE        1'b0
`define BITS_PER_BYTE   4'h8
`define ID_BYTE_FIRST   2'h0
`define ID_BYTE_MID     2'h1
`define ID_BYTE_LAST    2'h2
`define ID_MFG_W        12
`define ID_PART_W       9
`define ID_REV_W        3
`define ID_FIELD_B0     23:16
`define ID_FIELD_B1     15:8
`define ID_FIELD_B2     7:0
`define BYTE_MSB        7
`define ADDR_HI_W       4
// Upper address nibble, indexed by which pins follow a bus line
`define ADDR_HI_TABLE   32'hbaec3254
`define PIN_LVL_BIT     0
`define PIN_BUS_BIT     1
`define EXAMPLE_ADDR    7'h50

`endif

//--- i2c_slave_pkg.sv
// Types shared by the two-wire slave front end
package i2c_slave_pkg;

  typedef enum logic [1:0] {
    pin_vss = 2'b00,
    pin_vdd = 2'b01,
    pin_scl = 2'b10,
    pin_sda = 2'b11
  } pin_state_e;

  typedef enum logic [2:0] {
    st_idle   = 3'b000,
    st_addr   = 3'b001,
    st_gc     = 3'b010,
    st_idt    = 3'b011,
    st_tx     = 3'b100,
    st_ignore = 3'b101
  } link_state_e;

endpackage

//--- addr_pin_sense.sv
// Classifies one address pin as ground, supply, clock line or data line
`timescale 1ns/1ps
`default_nettype none
module addr_pin_sense
  import i2c_slave_pkg::*;
(
  input  wire logic  link_clk,
  input  wire logic  link_rst_n,
  input  wire logic  pin_raw,
  input  wire logic  scl_s,
  input  wire logic  sda_s,
  output pin_state_e pin_state
);

  logic pin_m;
  logic pin_s;
  logic seen_lo;
  logic seen_hi;
  logic differs_scl;
  logic next_seen_lo;
  logic next_seen_hi;
  logic next_differs_scl;
  pin_state_e next_pin_state;

  // Same two-stage delay as the bus lines, so the comparison is aligned
  always_ff @(posedge link_clk) begin
    pin_m <= pin_raw;
    pin_s <= pin_m;
  end

  assign next_seen_lo     = seen_lo | ~pin_s;
  assign next_seen_hi     = seen_hi | pin_s;
  assign next_differs_scl = differs_scl | (pin_s ^ scl_s);
  // A toggling pin follows a bus line; one that strays from the clock is data
  assign next_pin_state = (next_seen_lo & next_seen_hi) ?
                          (next_differs_scl ? pin_sda : pin_scl) :
                          (next_seen_hi ? pin_vdd : pin_vss);

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      seen_lo     <= 1'b0;
      seen_hi     <= 1'b0;
      differs_scl <= 1'b0;
      pin_state   <= pin_vss;
    end else begin
      seen_lo     <= next_seen_lo;
      seen_hi     <= next_seen_hi;
      differs_scl <= next_differs_scl;
      pin_state   <= next_pin_state;
    end
  end

endmodule
`default_nettype wire

//--- i2c_slave_addr_reset_id.sv
// Two-wire slave: pin-strapped address, general-call software reset, identification read
// Contract
// - Four-state address pins map to a fixed seven-bit slave address.
// - Acknowledge the general call address only when the byte is 00h.
// - General call address with read direction gets no acknowledge.
// - After general call, acknowledge the data byte only when it is 06h.
// - No acknowledge for any byte after the first general call data byte.
// - STOP after acknowledged 06h resets the device to power-up state; here it only emits a one-cycle soft_reset_pulse.
// - Repeated START after acknowledged 06h performs no reset.
// - Hardwired 24-bit identification: 12 maker, 9 part, 3 revision bits.
// - Master sends target address; only the owning device acknowledges it.
// - Lowest bit of the target address byte is ignored in comparison.
// - STOP, or access to another slave, abandons a pending identification read.
// - Identification is sent most significant bit first, revision in last bits.
// - Master non-acknowledge ends the read; slave state machine resets.
// - Continued acknowledges after the third byte wrap back to the first.
// - Last bit of an address byte: one reads, zero writes.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_regs.svh"
module i2c_slave_addr_reset_id
  import i2c_slave_pkg::*;
#(
  parameter logic [`ID_MFG_W-1:0]  MFG_CODE  = 12'h5a5, // Arbitrary value
  parameter logic [`ID_PART_W-1:0] PART_CODE = 9'h0c3,  // Arbitrary value
  parameter logic [`ID_REV_W-1:0]  REV_CODE  = 3'h1     // Arbitrary value
)(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        link_clk,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output wire logic        sda_o,
  output logic             sda_oe,
  input  wire logic        addr_select_pin_hi,
  input  wire logic        addr_select_pin_mid,
  input  wire logic        addr_select_pin_lo,
  output logic [6:0]       slave_addr,
  output logic             soft_reset_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic        link_rst_m;
  logic        link_rst_n;
  logic        scl_m;
  logic        scl_s;
  logic        scl_d;
  logic        sda_m;
  logic        sda_s;
  logic        sda_d;
  link_state_e state;
  link_state_e next_state;
  link_state_e follow;
  logic [3:0]  bitcnt;
  logic [3:0]  next_bitcnt;
  logic        ack_phase;
  logic        next_ack_phase;
  logic        next_drive;
  logic        id_armed;
  logic        next_id_armed;
  logic        reset_armed;
  logic        next_reset_armed;
  logic [1:0]  byte_idx;
  logic [1:0]  next_byte_idx;
  logic        reset_tgl;
  logic        next_reset_tgl;
  logic [7:0]  shreg;
  logic        tgl_m;
  logic        tgl_s;
  logic        tgl_d;
  pin_state_e  pin_code [0:2];

  wire logic [2:0]  addr_pins;
  wire logic [2:0]  bus_pat;
  wire logic [2:0]  lvl_bits;
  wire logic [31:0] addr_hi_table;
  wire logic [3:0]  addr_hi;
  wire logic [6:0]  next_slave_addr;
  wire logic        scl_rise;
  wire logic        scl_fall;
  wire logic        start_det;
  wire logic        stop_det;
  wire logic        rx_state;
  wire logic        shift_en;
  wire logic        is_gc_wr;
  wire logic        is_id_wr;
  wire logic        is_id_rd;
  wire logic        addr_ack;
  wire logic        gc_ack;
  wire logic        idt_ack;
  wire logic        ack_now;
  wire logic        ack_decide;
  wire logic [23:0] id_word;
  wire logic [7:0]  cur_byte;
  wire logic        tx_drive;

  ////////////////////////////////////////////////////////////////////////////
  // Reset and bus line synchronisers

  // Reset reaches the link domain through two stages of its own
  always_ff @(posedge link_clk) begin
    link_rst_m <= rst_n;
    link_rst_n <= link_rst_m;
  end

  always_ff @(posedge link_clk) begin
    scl_m <= scl_i;
    scl_s <= scl_m;
    sda_m <= sda_i;
    sda_s <= sda_m;
    scl_d <= scl_s;
    sda_d <= sda_s;
  end

  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

  // Open drain: only ever pull low
  assign sda_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Address pin sensing and address map

  assign addr_pins = {addr_select_pin_hi, addr_select_pin_mid, addr_select_pin_lo};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pin
      addr_pin_sense u_sense (
        .link_clk   (link_clk),
        .link_rst_n (link_rst_n),
        .pin_raw    (addr_pins[g]),
        .scl_s      (scl_s),
        .sda_s      (sda_s),
        .pin_state  (pin_code[g])
      );
    end
  endgenerate

  assign bus_pat  = {pin_code[2][`PIN_BUS_BIT], pin_code[1][`PIN_BUS_BIT], pin_code[0][`PIN_BUS_BIT]};
  assign lvl_bits = {pin_code[2][`PIN_LVL_BIT], pin_code[1][`PIN_LVL_BIT], pin_code[0][`PIN_LVL_BIT]};
  // A literal cannot be part-selected; hold the table in a named wire
  assign addr_hi_table = `ADDR_HI_TABLE;
  assign addr_hi  = addr_hi_table[bus_pat * `ADDR_HI_W +: `ADDR_HI_W];
  assign next_slave_addr = {addr_hi, lvl_bits};

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) slave_addr <= 7'h00;
    else             slave_addr <= next_slave_addr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte decoding

  assign rx_state   = (state == st_addr) | (state == st_gc) | (state == st_idt);
  assign shift_en   = scl_rise & ~ack_phase & rx_state & (bitcnt != `BITS_PER_BYTE);
  assign ack_decide = scl_fall & ~ack_phase & rx_state & (bitcnt == `BITS_PER_BYTE);

  assign is_gc_wr = (shreg == `GC_WRITE_BYTE);
  assign is_id_wr = (shreg == {`ID_ADDR, `RW_WRITE});
  assign is_id_rd = (shreg == {`ID_ADDR, `RW_READ}) & id_armed;
  assign addr_ack = is_gc_wr | is_id_wr | is_id_rd;
  assign gc_ack   = (shreg == `SW_RESET_BYTE);
  assign idt_ack  = (shreg[7:1] == slave_addr);
  assign ack_now  = (state == st_addr) ? addr_ack :
                    (state == st_gc)   ? gc_ack   :
                    (state == st_idt)  ? idt_ack  : 1'b0;
  // Every path but the three reserved ones falls silent until the next START
  assign follow = (state != st_addr) ? st_ignore :
                  is_gc_wr ? st_gc  :
                  is_id_wr ? st_idt :
                  is_id_rd ? st_tx  : st_ignore;

  assign id_word  = {MFG_CODE, PART_CODE, REV_CODE};
  assign cur_byte = (byte_idx == `ID_BYTE_FIRST) ? id_word[`ID_FIELD_B0] :
                    (byte_idx == `ID_BYTE_MID)   ? id_word[`ID_FIELD_B1] :
                                                   id_word[`ID_FIELD_B2];
  // Bit index is the complement of the count: MSB first
  assign tx_drive = (bitcnt == `BITS_PER_BYTE) ? 1'b0 : ~cur_byte[~bitcnt[2:0]];

  always_ff @(posedge link_clk) begin
    if (!link_rst_n)   shreg <= 8'h00;
    else if (shift_en) shreg <= {shreg[6:0], sda_s};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link state machine

  always_comb begin
    next_state       = state;
    next_bitcnt      = bitcnt;
    next_ack_phase   = ack_phase;
    next_drive       = sda_oe;
    next_id_armed    = id_armed;
    next_reset_armed = reset_armed;
    next_byte_idx    = byte_idx;
    next_reset_tgl   = reset_tgl;
    if (start_det) begin
      next_state       = st_addr;
      next_bitcnt      = 4'h0;
      next_ack_phase   = 1'b0;
      next_drive       = 1'b0;
      next_reset_armed = 1'b0;
    end else if (stop_det) begin
      next_state       = st_idle;
      next_ack_phase   = 1'b0;
      next_drive       = 1'b0;
      next_id_armed    = 1'b0;
      next_reset_armed = 1'b0;
      if (reset_armed) begin
        next_reset_tgl = ~reset_tgl;
      end
    end else if (scl_rise && !ack_phase) begin
      case (state)
        st_tx: begin
          if (bitcnt != `BITS_PER_BYTE) begin
            next_bitcnt = bitcnt + 4'h1;
          end else if (sda_s) begin
            next_state    = st_idle;
            next_id_armed = 1'b0;
          end else begin
            next_bitcnt   = 4'h0;
            next_byte_idx = (byte_idx == `ID_BYTE_LAST) ? `ID_BYTE_FIRST : byte_idx + 2'h1;
          end
        end
        st_addr, st_gc, st_idt: begin
          if (bitcnt != `BITS_PER_BYTE) begin
            next_bitcnt = bitcnt + 4'h1;
          end
        end
        default: begin
          next_state = state;
        end
      endcase
    end else if (scl_fall) begin
      if (ack_phase) begin
        next_ack_phase = 1'b0;
        next_bitcnt    = 4'h0;
        next_drive     = (state == st_tx) ? ~cur_byte[`BYTE_MSB] : 1'b0;
      end else if (ack_decide) begin
        next_ack_phase = 1'b1;
        next_drive     = ack_now;
        next_state     = follow;
        if (state == st_addr) begin
          // Any new address ends a pending identification request
          next_id_armed = 1'b0;
          next_byte_idx = `ID_BYTE_FIRST;
        end
        if (state == st_gc) begin
          next_reset_armed = gc_ack;
        end
        if (state == st_idt) begin
          next_id_armed = idt_ack;
        end
      end else if (state == st_tx) begin
        next_drive = tx_drive;
      end else if (state == st_ignore) begin
        // Only a fully clocked bit cancels; a STOP or Sr rise never falls first
        next_reset_armed = 1'b0;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      state       <= st_idle;
      bitcnt      <= 4'h0;
      ack_phase   <= 1'b0;
      sda_oe      <= 1'b0;
      id_armed    <= 1'b0;
      reset_armed <= 1'b0;
      byte_idx    <= `ID_BYTE_FIRST;
      reset_tgl   <= 1'b0;
    end else begin
      state       <= next_state;
      bitcnt      <= next_bitcnt;
      ack_phase   <= next_ack_phase;
      sda_oe      <= next_drive;
      id_armed    <= next_id_armed;
      reset_armed <= next_reset_armed;
      byte_idx    <= next_byte_idx;
      reset_tgl   <= next_reset_tgl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software reset crossing into the system clock

  // Toggle crossing: one event per flip, no pulse width to lose
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tgl_m            <= 1'b0;
      tgl_s            <= 1'b0;
      tgl_d            <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end else begin
      tgl_m            <= reset_tgl;
      tgl_s            <= tgl_m;
      tgl_d            <= tgl_s;
      soft_reset_pulse <= tgl_s ^ tgl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_addr_example;
    @(posedge link_clk) disable iff (!link_rst_n)
    (pin_code[2] == pin_scl && pin_code[1] == pin_scl && pin_code[0] == pin_vss)
      |=> (slave_addr == `EXAMPLE_ADDR);
  endproperty
  a_addr_example: assert property (p_addr_example) else $error("address map wrong");

  property p_gc_ack;
    @(posedge link_clk) disable iff (!link_rst_n)
    (ack_decide && state == st_addr && shreg == `GC_WRITE_BYTE) |=> (sda_oe && state == st_gc);
  endproperty
  a_gc_ack: assert property (p_gc_ack) else $error("general call not acknowledged");

  property p_gc_read_nack;
    @(posedge link_clk) disable iff (!link_rst_n)
    (ack_decide && state == st_addr && shreg == `GC_READ_BYTE) |=> (!sda_oe && state == st_ignore);
  endproperty
  a_gc_read_nack: assert property (p_gc_read_nack) else $error("general call read acknowledged");

  property p_reset_byte_ack;
    @(posedge link_clk) disable iff (!link_rst_n)
    (ack_decide && state == st_gc) |=> (sda_oe == ($past(shreg) == `SW_RESET_BYTE)) && (reset_armed == sda_oe);
  endproperty
  a_reset_byte_ack: assert property (p_reset_byte_ack) else $error("reset byte answer wrong");

  property p_ignore_quiet;
    @(posedge link_clk) disable iff (!link_rst_n)
    (state == st_ignore && !ack_phase) |-> !sda_oe;
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet) else $error("acknowledge after first byte");

  property p_stop_reset;
    @(posedge link_clk) disable iff (!link_rst_n)
    (stop_det && reset_armed) |=> (reset_tgl != $past(reset_tgl)) ##1 (reset_tgl == $past(reset_tgl));
  endproperty
  a_stop_reset: assert property (p_stop_reset) else $error("reset not issued on stop");

  property p_restart_no_reset;
    @(posedge link_clk) disable iff (!link_rst_n)
    (start_det) |=> (!reset_armed && $stable(reset_tgl));
  endproperty
  a_restart_no_reset: assert property (p_restart_no_reset) else $error("reset on repeated start");

  property p_target_match;
    @(posedge link_clk) disable iff (!link_rst_n)
    (ack_decide && state == st_idt) |=> (sda_oe == ($past(shreg[7:1]) == slave_addr)) && (id_armed == sda_oe);
  endproperty
  a_target_match: assert property (p_target_match) else $error("target address answer wrong");

  property p_stop_abandons;
    @(posedge link_clk) disable iff (!link_rst_n)
    (stop_det) |=> (!id_armed && state == st_idle && !sda_oe);
  endproperty
  a_stop_abandons: assert property (p_stop_abandons) else $error("identification survives stop");

  property p_nack_ends;
    @(posedge link_clk) disable iff (!link_rst_n)
    (state == st_tx && scl_rise && !ack_phase && bitcnt == `BITS_PER_BYTE && sda_s && !stop_det && !start_det)
      |=> (state == st_idle) ##1 !sda_oe;
  endproperty
  a_nack_ends: assert property (p_nack_ends) else $error("read not ended by nack");

  property p_wrap;
    @(posedge link_clk) disable iff (!link_rst_n)
    (state == st_tx && scl_rise && !ack_phase && bitcnt == `BITS_PER_BYTE && !sda_s && byte_idx == `ID_BYTE_LAST)
      |=> (byte_idx == `ID_BYTE_FIRST && state == st_tx);
  endproperty
  a_wrap: assert property (p_wrap) else $error("identification did not wrap");

  property p_pulse_single;
    @(posedge sys_clk) disable iff (!rst_n)
    soft_reset_pulse |=> !soft_reset_pulse;
  endproperty
  a_pulse_single: assert property (p_pulse_single) else $error("reset pulse longer than one cycle");

  c_soft_reset: cover property (@(posedge link_clk) disable iff (!link_rst_n) stop_det && reset_armed);
  c_id_read: cover property (@(posedge link_clk) disable iff (!link_rst_n)
    ack_decide && state == st_addr && is_id_rd);
  c_id_wrap: cover property (@(posedge link_clk) disable iff (!link_rst_n)
    state == st_tx && byte_idx == `ID_BYTE_LAST ##1 byte_idx == `ID_BYTE_FIRST);

endmodule
`default_nettype wire

//--- i2c_bus_master.sv
// Behavioural two-wire bus master that drives clock and data for the bench
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_master #(
  parameter int Q = 25
)(
  input  wire logic sys_clk,
  input  wire logic sda_in,
  output var logic  scl,
  output var logic  sda_low
);
  // Clock idles high between frames, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quarter bit; each phase far above the four link cycles the slave needs
  task automatic qw();
    repeat (Q) @(negedge sys_clk);
  endtask

  // Also serves as repeated start when called with the clock low
  task automatic bus_start();
    qw();
    sda_low = 1'b0;
    qw();
    scl = 1'b1;
    qw();
    sda_low = 1'b1;
    qw();
    scl = 1'b0;
  endtask

  task automatic bus_stop();
    qw();
    sda_low = 1'b1;
    qw();
    scl = 1'b1;
    qw();
    sda_low = 1'b0;
    qw();
  endtask

  // Data changes only while the clock is low, sampled mid high phase
  task automatic send_bit(input logic b, output logic s);
    qw();
    sda_low = ~b;
    qw();
    scl = 1'b1;
    qw();
    s = sda_in;
    qw();
    scl = 1'b0;
  endtask

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      send_bit(d[i], s);
    end
    send_bit(1'b1, s);
    ack = ~s;
  endtask

  task automatic read_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      send_bit(1'b1, d[i]);
    end
    send_bit(~ack, s);
  endtask
endmodule
`default_nettype wire

//--- i2c_slave_addr_reset_id_tb_top.sv
// Bench for the two-wire slave: reset call, identification read, address pins
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_regs.svh"
module i2c_slave_addr_reset_id_tb_top
  import i2c_slave_pkg::*;
;
  localparam logic [11:0] MFG     = 12'h3c9; // Arbitrary value
  localparam logic [8:0]  PART    = 9'h1a6;  // Arbitrary value
  localparam logic [2:0]  REV     = 3'h5;    // Arbitrary value
  localparam logic [23:0] ID_WORD = {MFG, PART, REV};

  logic       sys_clk;
  logic       link_clk;
  logic       rst_n;
  logic       scl;
  logic       m_low;
  logic       sda_line;
  logic       sda_o;
  logic       sda_oe;
  logic       pulse;
  logic [6:0] slave_addr;
  logic       pin_hi;
  logic       pin_mid;
  logic       pin_lo;
  pin_state_e cfg_hi;
  pin_state_e cfg_mid;
  pin_state_e cfg_lo;
  int         errors;
  int         cmp_count;
  int         pulse_cnt;
  int         exp_pulses;

  ////////////////////////////////////////////////////////////////////////////
  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;
  // Link clock free running, phase unrelated to the system clock
  initial link_clk = 1'b0;
  initial #1.3 forever #7.5 link_clk = ~link_clk;

  // Open drain with pull-up: low if either party pulls
  assign sda_line = ~(m_low | (sda_oe & ~sda_o));

  function automatic logic pin_lvl(pin_state_e c, logic c_scl, logic c_sda);
    return (c == pin_scl) ? c_scl : (c == pin_sda) ? c_sda : c[0];
  endfunction
  assign pin_hi  = pin_lvl(cfg_hi, scl, sda_line);
  assign pin_mid = pin_lvl(cfg_mid, scl, sda_line);
  assign pin_lo  = pin_lvl(cfg_lo, scl, sda_line);

  i2c_slave_addr_reset_id #(
    .MFG_CODE  (MFG),
    .PART_CODE (PART),
    .REV_CODE  (REV)
  ) u_i2c_slave_addr_reset_id (
    .sys_clk             (sys_clk),
    .rst_n               (rst_n),
    .link_clk            (link_clk),
    .scl_i               (scl),
    .sda_i               (sda_line),
    .sda_o               (sda_o),
    .sda_oe              (sda_oe),
    .addr_select_pin_hi  (pin_hi),
    .addr_select_pin_mid (pin_mid),
    .addr_select_pin_lo  (pin_lo),
    .slave_addr          (slave_addr),
    .soft_reset_pulse    (pulse)
  );

  i2c_bus_master u_i2c_bus_master (
    .sys_clk (sys_clk),
    .sda_in  (sda_line),
    .scl     (scl),
    .sda_low (m_low)
  );

  always @(posedge sys_clk) begin
    if (pulse === 1'b1) begin
      pulse_cnt <= pulse_cnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_addr(input logic [6:0] got, input logic [6:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_start();
    u_i2c_bus_master.bus_start();
  endtask

  task automatic t_stop();
    u_i2c_bus_master.bus_stop();
  endtask

  task automatic wr(input logic [7:0] d, input logic exp, input string what);
    logic ack;
    u_i2c_bus_master.write_byte(d, ack);
    chk_bit(ack, exp, what);
  endtask

  // Pulse lands a few system cycles after the stop; allow ample margin
  task automatic chk_pulses(input int n);
    repeat (40) @(negedge sys_clk);
    exp_pulses += n;
    chk_byte(8'(pulse_cnt), 8'(exp_pulses), "reset pulses");
  endtask

  // Held long enough for the link domain to see it too
  task automatic do_reset(input pin_state_e h, input pin_state_e m, input pin_state_e l);
    rst_n = 1'b0;
    cfg_hi = h;
    cfg_mid = m;
    cfg_lo = l;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (20) @(negedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_soft_reset();
    t_start();
    wr(`GC_WRITE_BYTE, 1'b1, "gc addr");
    wr(`SW_RESET_BYTE, 1'b1, "reset byte");
    t_stop();
    chk_pulses(1);
  endtask

  task automatic t_gc_refused();
    t_start();
    wr(`GC_READ_BYTE, 1'b0, "gc read");
    t_stop();
    t_start();
    wr(`GC_WRITE_BYTE, 1'b1, "gc addr");
    wr(8'h07, 1'b0, "bad reset byte");
    t_stop();
    chk_pulses(0);
    t_start();
    wr(`GC_WRITE_BYTE, 1'b1, "gc addr");
    wr(`SW_RESET_BYTE, 1'b1, "reset byte");
    wr(`SW_RESET_BYTE, 1'b0, "extra byte");
    t_stop();
    chk_pulses(0);
    t_start();
    wr(`GC_WRITE_BYTE, 1'b1, "gc addr");
    wr(`SW_RESET_BYTE, 1'b1, "reset byte");
    t_start();
    wr(8'hc0, 1'b0, "other slave");
    t_stop();
    chk_pulses(0);
  endtask

  // Four bytes read: the fourth must wrap to the first
  task automatic t_id_read(input logic [7:0] target);
    logic [7:0] d;
    t_start();
    wr({`ID_ADDR, `RW_WRITE}, 1'b1, "id write");
    wr(target, 1'b1, "own target");
    t_start();
    wr({`ID_ADDR, `RW_READ}, 1'b1, "id read");
    for (int i = 0; i < 4; i++) begin
      u_i2c_bus_master.read_byte(i < 3, d);
      chk_byte(d, ID_WORD[23 - 8 * (i % 3) -: 8], "id byte");
    end
    t_stop();
    t_start();
    wr({`ID_ADDR, `RW_READ}, 1'b0, "id read after nack");
    t_stop();
  endtask

  task automatic t_id_abandon();
    t_start();
    wr({`ID_ADDR, `RW_WRITE}, 1'b1, "id write");
    wr(8'ha0, 1'b1, "own target");
    t_stop();
    t_start();
    wr({`ID_ADDR, `RW_READ}, 1'b0, "id after stop");
    wr({`ID_ADDR, `RW_WRITE}, 1'b0, "silent until stop");
    t_stop();
    t_start();
    wr({`ID_ADDR, `RW_WRITE}, 1'b1, "id write");
    wr(8'ha1, 1'b1, "own target");
    t_start();
    wr(8'hc0, 1'b0, "other slave");
    t_start();
    wr({`ID_ADDR, `RW_READ}, 1'b0, "id after other");
    t_stop();
    t_start();
    wr({`ID_ADDR, `RW_WRITE}, 1'b1, "id write");
    wr(8'hc1, 1'b0, "foreign target");
    t_stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    cmp_count = 0;
    pulse_cnt = 0;
    exp_pulses = 0;
    do_reset(pin_scl, pin_scl, pin_vss);
    t_soft_reset();
    chk_addr(slave_addr, `EXAMPLE_ADDR, "pins scl scl gnd");
    t_gc_refused();
    t_id_read(8'ha1);
    t_id_abandon();
    do_reset(pin_sda, pin_vdd, pin_sda);
    t_soft_reset();
    t_id_read(8'hee);
    chk_addr(slave_addr, 7'h77, "pins sda vdd sda");
    final_report();
  end

  initial begin
    repeat (90000) @(posedge sys_clk);
    errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    final_report();
  end
endmodule
`default_nettype wire
